// >>> core/repeater_pkg.sv
package repeater_pkg;

  // Core clock and the local transmit oscillator rate.
  localparam int CLK_MHZ = 250;
  localparam int LOCAL_CLK_KHZ = 1000;
  localparam int CNT_W = 24;
  typedef logic [CNT_W-1:0] cnt_t;

  // Printed times in their own units.
  localparam int FLAG_WIN_MS = 40;
  localparam int FLAG_LED_US = 10;
  localparam int TX_ACT_US = 10;
  localparam int DEBOUNCE_US = 1000;

  // Cycle counts derived from the times above.
  localparam int LOCAL_DIV_I = CLK_MHZ * 1000 / LOCAL_CLK_KHZ;
  localparam int FLAG_WIN_CYC = FLAG_WIN_MS * 1000 * CLK_MHZ;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  localparam cnt_t LOCAL_DIV = CNT_W'(LOCAL_DIV_I);
  localparam cnt_t HALF_CYC = CNT_W'(LOCAL_DIV_I / 2);
  localparam cnt_t MID_MIN = CNT_W'(LOCAL_DIV_I * 3 / 4);
  localparam cnt_t LOSS_CYC = CNT_W'(LOCAL_DIV_I * 2);
  localparam cnt_t FLAG_LED_CYC = CNT_W'(FLAG_LED_US * CLK_MHZ);
  localparam cnt_t TX_ACT_CYC = CNT_W'(TX_ACT_US * CLK_MHZ);

  // Idle flag pattern watched by the envelope detector.
  localparam int FLAG_LEN = 7;
  localparam logic [FLAG_LEN-1:0] FLAG_PAT = 7'h3E;

  // Depth of the bypass bit buffer.
  localparam int FIFO_DEPTH = 16;

  // Pins arriving from outside the core clock domain.
  typedef struct packed {
    logic line_rx;
    logic station_tx;
    logic rts;
    logic flag_det;
    logic loop_online_control;
    logic bypass_sw;
    logic power_ok;
    logic cable_ok;
  } pins_t;

  // Reset levels of the pin synchronisers. The line idles high, so the decoder sees no false edge after reset.
  // Every other pin reads inactive, so a dark station still reads as bypassed.
  localparam pins_t SYNC_IDLE = '{line_rx: 1'b1, default: 1'b0};

  // The four independent reasons for skipping the station.
  typedef struct packed {
    logic online_off;
    logic manual;
    logic power_off;
    logic cable_off;
  } cause_t;

  typedef enum logic [1:0] {
    ENC_IDLE = 2'b00,
    ENC_FIRST = 2'b01,
    ENC_SECOND = 2'b10
  } enc_state_t;

endpackage

// >>> core/bit_fifo.sv
`timescale 1ns/100ps
module bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  typedef logic [PW:0] ptr_t;
  localparam ptr_t DEPTH_P = (PW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  ptr_t wr_r, wr_nxt, rd_r, rd_nxt, fill;
  logic push, pop;

  // Full and empty come from the pointer distance, so both stay exact.
  always_comb begin
    fill = wr_r - rd_r;
    in_ready = fill != DEPTH_P;
    out_valid = fill != '0;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_nxt = push ? wr_r + 1'b1 : wr_r;
    rd_nxt = pop ? rd_r + 1'b1 : rd_r;
  end

  // Pointers and storage.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
    end
    if (push) begin
      mem[wr_r[PW-1:0]] <= in_data;
    end
  end

  // The head word is read straight from the array for a same-cycle pop.
  assign out_data = mem[rd_r[PW-1:0]];
endmodule

// >>> core/loop_link_repeater_logic.sv
`timescale 1ns/100ps
// What this block does
// - Bypass on online-off, switch, power, or cable.
// - Manual bypass acts at once, mid-message.
// - In bypass, received bits feed the encoder.
// - Transmit clock normally is the recovered clock.
// - Request-to-send selects local 1 MHz clock.
// - Outside bypass, station serial data is transmitted.
// - Envelope: data not flag, flag seen 40 ms.
// - Split Manchester line into clock and data.
// - Encode as clock XOR data, then latch.
// - Flag pulses retrigger a 10 us indicator.
// - Transmit activity indicator dies on constant data.
// - Debounce the manual bypass switch.
// - One status per cause plus combined status.
// - Indicators active low; local clock indicator.
// - Return active-low bypass status to station.
module loop_link_repeater_logic #(
  parameter int FLAG_WIN = repeater_pkg::FLAG_WIN_CYC,
  parameter int DEBOUNCE = repeater_pkg::DEBOUNCE_CYC
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire repeater_pkg::pins_t pin_in,
  output logic station_skip_out,
  output logic link_bypass_n,
  output logic line_tx_clock,
  output logic line_tx_bits,
  output logic recovered_rx_clock,
  output logic rx_message_envelope,
  output logic rx_overrun,
  output repeater_pkg::cause_t cause_led_n,
  output logic bypass_led_n,
  output logic local_clk_led_n,
  output logic flag_led_n,
  output logic tx_act_led_n
);
  import repeater_pkg::*;

  localparam cnt_t FLAG_WIN_C = CNT_W'(FLAG_WIN);
  localparam cnt_t DEBOUNCE_C = CNT_W'(DEBOUNCE);
  localparam int PIN_W = $bits(pins_t);

  // Every pin passes two flops; only the second stage is used by logic.
  logic [PIN_W-1:0] s1_r, s2_q;
  pins_t s2_r;
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          s1_r[gi] <= SYNC_IDLE[gi];
          s2_q[gi] <= SYNC_IDLE[gi];
        end else begin
          s1_r[gi] <= pin_in[gi];
          s2_q[gi] <= s1_r[gi];
        end
      end
    end
  endgenerate
  assign s2_r = pins_t'(s2_q);

  // Counter helper shared by every one-shot in the block.
  function automatic cnt_t count_down(input cnt_t c);
    count_down = (c != '0) ? c - 1'b1 : '0;
  endfunction

  // Manchester decoder state.
  logic line_prev_r, line_prev_nxt, line_edge;
  cnt_t dec_cnt_r, dec_cnt_nxt;
  logic locked_r, locked_nxt, rx_bit_r, rx_bit_nxt;
  logic rx_stb_r, rx_stb_nxt, rclk_r, rclk_nxt;

  // Once locked, a transition counts as mid-bit only when at least three quarters of a
  // bit has passed, which rejects the boundary edges between equal bits.
  always_comb begin
    line_prev_nxt = s2_r.line_rx;
    line_edge = s2_r.line_rx ^ line_prev_r;
    dec_cnt_nxt = dec_cnt_r;
    locked_nxt = locked_r;
    rx_bit_nxt = rx_bit_r;
    rx_stb_nxt = 1'b0;
    if (line_edge && (!locked_r || dec_cnt_r >= MID_MIN)) begin
      dec_cnt_nxt = '0;
      locked_nxt = 1'b1;
      rx_bit_nxt = s2_r.line_rx;
      rx_stb_nxt = 1'b1;
    end else if (dec_cnt_r >= LOSS_CYC) begin
      locked_nxt = 1'b0;
    end else begin
      dec_cnt_nxt = dec_cnt_r + 1'b1;
    end
    rclk_nxt = locked_nxt && (dec_cnt_nxt < HALF_CYC);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      line_prev_r <= SYNC_IDLE.line_rx;
      dec_cnt_r <= '0;
      locked_r <= 1'b0;
      rx_bit_r <= 1'b0;
      rx_stb_r <= 1'b0;
      rclk_r <= 1'b0;
    end else begin
      line_prev_r <= line_prev_nxt;
      dec_cnt_r <= dec_cnt_nxt;
      locked_r <= locked_nxt;
      rx_bit_r <= rx_bit_nxt;
      rx_stb_r <= rx_stb_nxt;
      rclk_r <= rclk_nxt;
    end
  end

  // Envelope detector state.
  logic [FLAG_LEN-1:0] hist_r, hist_nxt;
  cnt_t flag_tmr_r, flag_tmr_nxt;
  logic env_r, env_nxt, flag_hit;

  // The flag window proves the link works; a non-flag window shows data.
  always_comb begin
    hist_nxt = rx_stb_r ? {hist_r[FLAG_LEN-2:0], rx_bit_r} : hist_r;
    flag_hit = rx_stb_r && (hist_nxt == FLAG_PAT);
    flag_tmr_nxt = flag_hit ? FLAG_WIN_C : count_down(flag_tmr_r);
    env_nxt = (flag_tmr_nxt != '0) && (hist_nxt != FLAG_PAT);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hist_r <= '0;
      flag_tmr_r <= '0;
      env_r <= 1'b0;
    end else begin
      hist_r <= hist_nxt;
      flag_tmr_r <= flag_tmr_nxt;
      env_r <= env_nxt;
    end
  end

  // Bypass selection state.
  logic sw_r, sw_nxt, bypass_r, bypass_nxt;
  cnt_t db_cnt_r, db_cnt_nxt;
  cause_t cause_r, cause_nxt;

  // The switch is accepted on its first closed sample, so bypass is not
  // delayed; only the release waits out the bounce time.
  always_comb begin
    sw_nxt = sw_r;
    db_cnt_nxt = count_down(db_cnt_r);
    if (s2_r.bypass_sw) begin
      sw_nxt = 1'b1;
      db_cnt_nxt = DEBOUNCE_C;
    end else if (db_cnt_r == '0) begin
      sw_nxt = 1'b0;
    end
    // Pins float low when the station is dark or unplugged.
    cause_nxt.online_off = !s2_r.loop_online_control;
    cause_nxt.manual = sw_nxt;
    cause_nxt.power_off = !s2_r.power_ok;
    cause_nxt.cable_off = !s2_r.cable_ok;
    bypass_nxt = |cause_nxt;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sw_r <= 1'b0;
      db_cnt_r <= '0;
      cause_r <= '0;
      bypass_r <= 1'b0;
    end else begin
      sw_r <= sw_nxt;
      db_cnt_r <= db_cnt_nxt;
      cause_r <= cause_nxt;
      bypass_r <= bypass_nxt;
    end
  end

  // Local oscillator divider, running only while request-to-send is up.
  cnt_t div_cnt_r, div_cnt_nxt;
  logic loc_stb, tx_stb;

  always_comb begin
    div_cnt_nxt = '0;
    if (s2_r.rts && div_cnt_r != LOCAL_DIV - 1'b1) begin
      div_cnt_nxt = div_cnt_r + 1'b1;
    end
    loc_stb = s2_r.rts && (div_cnt_r == '0);
    tx_stb = s2_r.rts ? loc_stb : rx_stb_r;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
    end
  end

  // Received bits wait here in bypass; the encoder drains them on its own
  // clock, which differs from the receive rate once the local clock runs.
  logic fifo_in_ready, fifo_out_valid, fifo_head, fifo_pop_ready;
  logic fifo_push, ovr_r, ovr_nxt;

  assign fifo_push = rx_stb_r && bypass_r;
  assign fifo_pop_ready = tx_stb && bypass_r;

  bit_fifo #(
    .WIDTH(1),
    .DEPTH(FIFO_DEPTH)
  ) u_bypass_fifo (
    .ref_clk(ref_clk),
    .srst(srst || !bypass_r), // Emptied outside bypass, so a stale bit never leads the next bypass.
    .in_data(rx_bit_r),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .out_data(fifo_head),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop_ready)
  );

  // A refused push loses a bit; it is reported until bypass ends.
  always_comb begin
    ovr_nxt = bypass_r && (ovr_r || (fifo_push && !fifo_in_ready));
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ovr_r <= 1'b0;
    end else begin
      ovr_r <= ovr_nxt;
    end
  end

  // Manchester encoder state.
  enc_state_t enc_state_r, enc_state_nxt;
  cnt_t half_cnt_r, half_cnt_nxt, act_cnt_r, act_cnt_nxt;
  logic tx_bit_r, tx_bit_nxt, tx_src, line_out_r, line_out_nxt;
  logic tclk_r, tclk_nxt;

  // Each bit is sent as inverted data then true data: data XOR a clock
  // that is high in the first half, latched here so the pin is glitch free.
  always_comb begin
    enc_state_nxt = enc_state_r;
    half_cnt_nxt = half_cnt_r + 1'b1;
    tx_bit_nxt = tx_bit_r;
    act_cnt_nxt = count_down(act_cnt_r);
    tx_src = s2_r.station_tx;
    if (bypass_r) begin
      tx_src = fifo_out_valid ? fifo_head : 1'b1;
    end
    tclk_nxt = s2_r.rts ? (div_cnt_r < HALF_CYC) : rclk_r;
    if (tx_stb) begin
      tx_bit_nxt = tx_src;
      enc_state_nxt = ENC_FIRST;
      half_cnt_nxt = '0;
      if (tx_src != tx_bit_r) begin
        act_cnt_nxt = TX_ACT_CYC;
      end
    end else begin
      case (enc_state_r)
        ENC_FIRST: begin
          if (half_cnt_r >= HALF_CYC - 1'b1) begin
            enc_state_nxt = ENC_SECOND;
          end
        end
        ENC_SECOND: begin
          if (half_cnt_r >= LOSS_CYC) begin
            enc_state_nxt = ENC_IDLE;
          end
        end
        ENC_IDLE: begin
          half_cnt_nxt = half_cnt_r;
        end
        default: begin
          enc_state_nxt = ENC_IDLE;
        end
      endcase
    end
    line_out_nxt = line_out_r;
    if (enc_state_nxt != ENC_IDLE) begin
      line_out_nxt = tx_bit_nxt ^ (enc_state_nxt == ENC_FIRST);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      enc_state_r <= ENC_IDLE;
      half_cnt_r <= '0;
      act_cnt_r <= '0;
      tx_bit_r <= 1'b0;
      line_out_r <= 1'b0;
      tclk_r <= 1'b0;
    end else begin
      enc_state_r <= enc_state_nxt;
      half_cnt_r <= half_cnt_nxt;
      act_cnt_r <= act_cnt_nxt;
      tx_bit_r <= tx_bit_nxt;
      line_out_r <= line_out_nxt;
      tclk_r <= tclk_nxt;
    end
  end

  // Flag indicator one-shot, retriggered on each rising flag pulse.
  logic flag_prev_r, flag_prev_nxt;
  cnt_t flag_cnt_r, flag_cnt_nxt;

  always_comb begin
    flag_prev_nxt = s2_r.flag_det;
    flag_cnt_nxt = count_down(flag_cnt_r);
    if (s2_r.flag_det && !flag_prev_r) begin
      flag_cnt_nxt = FLAG_LED_CYC;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flag_prev_r <= 1'b0;
      flag_cnt_r <= '0;
    end else begin
      flag_prev_r <= flag_prev_nxt;
      flag_cnt_r <= flag_cnt_nxt;
    end
  end

  // Outputs; all indicators pull low when active.
  assign station_skip_out = bypass_r;
  assign link_bypass_n = !bypass_r;
  assign cause_led_n = ~cause_r;
  assign bypass_led_n = !bypass_r;
  assign local_clk_led_n = !s2_r.rts;
  assign flag_led_n = (flag_cnt_r == '0);
  assign tx_act_led_n = (act_cnt_r == '0);
  assign line_tx_clock = tclk_r;
  assign line_tx_bits = line_out_r;
  assign recovered_rx_clock = rclk_r;
  assign rx_message_envelope = env_r;
  assign rx_overrun = ovr_r;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  a_power_bypass: assert property (!s2_r.power_ok |=> station_skip_out)
    else $error("power loss did not bypass");
  a_manual_fast: assert property ($rose(s2_r.bypass_sw) |=> station_skip_out && !cause_led_n.manual)
    else $error("manual bypass was late");
  a_switch_hold: assert property ($fell(sw_r) |-> $past(!s2_r.bypass_sw, 2))
    else $error("switch released without debounce");
  a_bypass_route: assert property (tx_stb && bypass_r && fifo_out_valid |=> tx_bit_r == $past(fifo_head))
    else $error("bypass did not send received bit");
  a_station_route: assert property (tx_stb && !bypass_r |=> tx_bit_r == $past(s2_r.station_tx))
    else $error("station bit not sent");
  a_rx_clock_src: assert property (rx_stb_r && !s2_r.rts |=> enc_state_r == ENC_FIRST)
    else $error("recovered clock did not start a bit");
  a_local_rate: assert property (loc_stb |=> !loc_stb [*8])
    else $error("local clock too fast");
  a_enc_halves: assert property (tx_stb ##1 !tx_stb [*8] |-> line_tx_bits != tx_bit_r)
    else $error("first half not inverted");
  a_enc_second: assert property (enc_state_r == ENC_SECOND |-> line_tx_bits == tx_bit_r)
    else $error("second half not true data");
  a_mid_reject: assert property (line_edge && locked_r && dec_cnt_r < MID_MIN |=> !rx_stb_r)
    else $error("boundary edge taken as data");
  a_envelope: assert property (rx_message_envelope |-> flag_tmr_r != '0 && hist_r != FLAG_PAT)
    else $error("envelope without flag or on flag");
  a_flag_led: assert property (s2_r.flag_det && !flag_prev_r |=> !flag_led_n [*8])
    else $error("flag indicator not lit");
endmodule

// >>> tb/link_partner.sv
`timescale 1ns/100ps
// Far-end repeater that puts Manchester bits on the incoming line.
module link_partner (
  input wire logic ref_clk,
  output logic line_rx
);
  // The line idles high, so a frame that opens with a 0 has no edge at its first bit boundary.
  initial begin
    line_rx = 1'b1;
  end

  // Hold one level for n core cycles; the level changes just after a falling edge.
  task automatic drive_half(input logic v, input int n);
    @(negedge ref_clk);
    line_rx = v;
    repeat (n - 1) @(negedge ref_clk);
  endtask

  // A rising mid-bit edge carries a 1 and a falling one carries a 0.
  task automatic send_bit(input logic b);
    drive_half(~b, 125);
    drive_half(b, 125);
  endtask

  // Send a run of bits, oldest first.
  task automatic send_bits(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      send_bit(v[i]);
    end
  endtask
endmodule

// >>> tb/tb.sv
`timescale 1ns/100ps
module tb;
  import repeater_pkg::*;
  localparam int FW = 5000;
  localparam int DB = 50;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic stx = 1'b0;
  logic rts = 1'b0;
  logic fdet = 1'b0;
  logic online = 1'b1;
  logic sw = 1'b0;
  logic pwr = 1'b1;
  logic cable = 1'b1;
  logic rx_line;
  pins_t pins;
  logic skip, bypass_n, tx_clk, tx_bits, rx_clk, env, overrun, byp_led_n, lclk_led_n, flag_led_n, act_led_n;
  cause_t cause_n;
  int errors = 0;
  int samples_checked = 0;
  int rclk_rises, tclk_rises, bit_changes;

  // The pin fields are packed in the order the struct declares them.
  assign pins = {rx_line, stx, rts, fdet, online, sw, pwr, cable};

  loop_link_repeater_logic #(.FLAG_WIN(FW), .DEBOUNCE(DB)) loop_link_repeater_logic_i (.ref_clk(ref_clk),
    .srst(srst), .pin_in(pins), .station_skip_out(skip), .link_bypass_n(bypass_n), .line_tx_clock(tx_clk),
    .line_tx_bits(tx_bits), .recovered_rx_clock(rx_clk), .rx_message_envelope(env), .rx_overrun(overrun),
    .cause_led_n(cause_n), .bypass_led_n(byp_led_n), .local_clk_led_n(lclk_led_n), .flag_led_n(flag_led_n),
    .tx_act_led_n(act_led_n));

  link_partner link_partner_i (.ref_clk(ref_clk), .line_rx(rx_line));

  // Core clock at 250 MHz.
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  // Case equality keeps an unknown output from passing as a match.
  task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Count recovered and transmit clock rises and transmit bit changes over n cycles.
  task automatic measure(input int n);
    logic pr, pt, pb;
    rclk_rises = 0;
    tclk_rises = 0;
    bit_changes = 0;
    pr = rx_clk;
    pt = tx_clk;
    pb = tx_bits;
    repeat (n) begin
      @(negedge ref_clk);
      if (rx_clk === 1'b1 && pr === 1'b0) rclk_rises++;
      if (tx_clk === 1'b1 && pt === 1'b0) tclk_rises++;
      if (tx_bits !== pb) bit_changes++;
      pr = rx_clk;
      pt = tx_clk;
      pb = tx_bits;
    end
  endtask

  task automatic pulse_flag;
    fdet = 1'b1;
    wait_cyc(2);
    fdet = 1'b0;
  endtask

  // Send eight zeros, then stop 60 cycles past the mid-bit edge of the next zero to see the sent bit's first half on the line.
  task automatic tx_phase(input logic exp, input string msg);
    link_partner_i.send_bits(16'h0000, 8);
    link_partner_i.drive_half(1'b1, 125);
    link_partner_i.drive_half(1'b0, 60);
    chk(tx_bits, exp, msg);
    link_partner_i.drive_half(1'b0, 65);
    link_partner_i.drive_half(1'b1, 1);
  endtask

  task automatic done_test(input string name);
    $display("test %s done", name);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // The tests take about 31000 cycles; a hang is cut off well beyond that.
  initial begin
    #200000;
    errors++;
    report_and_stop();
  end

  initial begin
    repeat (4) @(negedge ref_clk);
    srst = 1'b0;
    wait_cyc(4);
    chk({skip, bypass_n, byp_led_n, lclk_led_n}, 4'h7, "idle status");
    chk(cause_n, 4'hF, "idle cause leds");
    chk({flag_led_n, act_led_n}, 4'h3, "idle indicators");
    done_test("reset");

    // Raise each cause alone; the online line changes with no traffic on the loop.
    for (int c = 0; c < 4; c++) begin
      {online, sw, pwr, cable} = 4'hB ^ (4'h8 >> c);
      wait_cyc(4);
      chk({skip, bypass_n, byp_led_n}, 4'h4, "bypass on cause");
      chk(cause_n, ~(4'h8 >> c), "cause led");
      {online, sw, pwr, cable} = 4'hB;
      wait_cyc(4);
      chk(skip, c == 1, "release of cause");
      wait_cyc(DB + 8);
      chk({skip, bypass_n}, 4'h1, "bypass ends");
    end
    done_test("bypass causes");

    // Local oscillator drives the transmitter. Constant station data lets the activity one-shot
    // run out, and a change of the data must retrigger it.
    rts = 1'b1;
    stx = 1'b1;
    wait_cyc(4);
    chk(lclk_led_n, 1'b0, "local clock led");
    measure(2500);
    chk(tclk_rises >= 9 && tclk_rises <= 11, 1'b1, "local clock rate");
    chk(bit_changes >= 18 && bit_changes <= 21, 1'b1, "two changes per bit");
    wait_cyc(300);
    chk(act_led_n, 1'b1, "activity led off on constant data");
    stx = 1'b0;
    wait_cyc(300);
    chk(act_led_n, 1'b0, "activity led on");
    stx = 1'b1;
    rts = 1'b0;
    wait_cyc(2800);
    chk({act_led_n, lclk_led_n}, 4'h3, "activity led off");
    done_test("local clock");

    pulse_flag();
    wait_cyc(10);
    chk(flag_led_n, 1'b0, "flag led on");
    wait_cyc(2000);
    pulse_flag();
    wait_cyc(2000);
    chk(flag_led_n, 1'b0, "flag led retriggered");
    wait_cyc(600);
    chk(flag_led_n, 1'b1, "flag led off");
    done_test("flag indicator");

    // Bypass forwards the received clock and bits; station data must not leak through.
    online = 1'b0;
    wait_cyc(600);
    fork
      link_partner_i.send_bits(16'h0555, 12);
      measure(3000);
    join
    chk(rclk_rises >= 11 && rclk_rises <= 12, 1'b1, "recovered clock count");
    chk(tclk_rises == rclk_rises, 1'b1, "transmit clock follows recovered");
    chk(overrun, 1'b0, "no overrun");
    tx_phase(1'b1, "bypass forwards received bit");
    online = 1'b1;
    wait_cyc(600);
    chk(skip, 1'b0, "back online");
    tx_phase(1'b0, "station bit transmitted");
    done_test("forwarding");

    // Envelope needs non-flag data and a flag within the window.
    link_partner_i.send_bits(16'h003E, 7);
    chk(env, 1'b0, "flag is not data");
    link_partner_i.send_bits(16'h0000, 8);
    chk(env, 1'b1, "data after flag");
    link_partner_i.drive_half(1'b1, 1);
    wait_cyc(FW + 500);
    link_partner_i.send_bits(16'h0000, 8);
    chk(env, 1'b0, "no recent flag");
    link_partner_i.drive_half(1'b1, 1);
    done_test("envelope");
    report_and_stop();
  end
endmodule
